// [lfw_defs.vh]
// Constants for the LF wake-up receiver back end
`ifndef LFW_DEFS_VH
`define LFW_DEFS_VH
// Register byte offsets
`define LFW_OFS_CTRL 8'h00
`define LFW_OFS_CDATA 8'h04
`define LFW_OFS_RXBUF 8'h08
`define LFW_OFS_RSSI 8'h0c
`define LFW_OFS_HDR 8'h10
`define LFW_OFS_ID 8'h14
`define LFW_OFS_FLAG 8'h18
// Control register fields
`define LFW_CTRL_RESET 8'h00
`define LFW_TRIM_HI 7
`define LFW_TRIM_LO 5
`define LFW_SENS_BIT 4
`define LFW_MODE_HI 3
`define LFW_MODE_LO 2
`define LFW_BURST_BIT 1
`define LFW_EN_BIT 0
// Wake-up modes
`define LFW_MODE_GAP 2'h0
`define LFW_MODE_HDR 2'h1
`define LFW_MODE_HDR_ID 2'h2
`define LFW_MODE_TRANSP 2'h3
// Control and data register fields
`define LFW_CAPT_BIT 7
`define LFW_FERST_BIT 6
`define LFW_RAW_BIT 0
// Flag register fields
`define LFW_FLG_RSSI 3
`define LFW_FLG_EOD 2
`define LFW_FLG_BUF 1
`define LFW_FLG_WAKE 0
// Timing
`define LFW_CLK_HZ 10000000
`define LFW_CARRIER_HZ 125000
`define LFW_BIT_NS 256000
`define LFW_TIMEOUT_US 2000
`define LFW_PREAMBLE_PERIODS 128
`define LFW_GAP_CONT 8
`define LFW_GAP_BURST 24
`define LFW_AGC_UP_PERIODS 4
`define LFW_HDR_BITS 7
`define LFW_ID_BITS 16
`endif

// [lfw_lf_tx.sv]
// Behavioural LF transmitter seen through the comparator outputs
`timescale 1ns/1ps
`default_nettype none
module lfw_lf_tx
#(
   parameter PERIOD_CYC = 80
)
(
   // Clock
   input wire logic i_core_clk,
   // Comparator levels
   output logic o_carrier_cmp,
   output logic o_amp_above_ref
);
   initial
   begin
      o_carrier_cmp = 1'b0;
      o_amp_above_ref = 1'b0;
   end
   task automatic hold(input logic lvl, input logic amp, input int periods);
      repeat (periods * PERIOD_CYC) @(posedge i_core_clk)
      begin
         o_carrier_cmp <= lvl;
         o_amp_above_ref <= lvl && amp;
      end
   endtask
   // Weak preamble, below reference, so the gain has to climb
   task automatic preamble(input int periods);
      hold(1'b1, 1'b0, periods);
   endtask
   // Strong data: high halves exceed the reference
   task automatic manchester(input logic [31:0] data, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         hold(data[i], 1'b1, 16);
         hold(!data[i], 1'b1, 16);
      end
   endtask
endmodule
`default_nettype wire

// [lfw_manchester.v]
// Manchester bit decoder for the LF wake-up receiver
`timescale 1ns/1ps
`default_nettype none
`include "lfw_defs.vh"
module lfw_manchester
#(
   parameter BIT_CYC = (`LFW_BIT_NS / 100) * (`LFW_CLK_HZ / 10000000)
)
(
   // Clock and reset
   input wire i_core_clk,
   input wire i_srst,
   // Control and envelope
   input wire i_run,
   input wire i_env,
   // Decoded bits
   output reg o_bit_valid,
   output reg o_bit_value,
   output reg o_bit_error
);
   reg [15:0] cyc;
   reg first_half;
   // Sample each half in its middle to tolerate envelope delay
   always @(posedge i_core_clk)
   begin
      if (i_srst || !i_run)
      begin
         cyc <= 16'h0000;
         first_half <= 1'b0;
         o_bit_valid <= 1'b0;
         o_bit_value <= 1'b0;
         o_bit_error <= 1'b0;
      end
      else
      begin
         o_bit_valid <= 1'b0;
         o_bit_error <= 1'b0;
         if (cyc == BIT_CYC[15:0] - 16'h0001)
            cyc <= 16'h0000;
         else
            cyc <= cyc + 16'h0001;
         if (cyc == BIT_CYC[17:2])
            first_half <= i_env;
         if (cyc == BIT_CYC[17:2] * 16'h0003)
         begin
            if (first_half != i_env)
            begin
               o_bit_valid <= 1'b1;
               o_bit_value <= first_half;
            end
            else
               o_bit_error <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [lfw_receiver.v]
// LF wake-up receiver back end with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "lfw_defs.vh"
// How it works
// - Without carrier stay in listen, decoder clock and logic asleep.
// - No valid code within 2 ms of decoder wake: back to listen.
// - Decode Manchester, match header/identifier, then raise wake-up flag.
// - After wake-up, bytes go to receive buffer and set buffer-full.
// - Raw data bit readable and routed to capture timer input.
// - Raw data bit is the envelope from the carrier comparator, bypassing decoder.
// - Mode 11 is transparent: raw data for slow software decoding.
// - Preamble valid after 128 periods; gaps over 8 or 24 clear.
// - Preamble found: start oscillator, wake decoder, await start sync.
// - After start sync, receive according to selected wake-up mode.
// - Capture enable copies AGC gain into RSSI register and sets ready flag on the same edge.
// - AGC steps gain down on one high period, up after four low.
// - Gain regulation only while signal above half reference.
// - Conditioner gives binary envelope, filters spaces and glitches.
// - Envelope feeds raw output, wake-up logic and preamble detector.
// - Control bits 7..5 select trimming capacitance.
// - Control bit 4 selects input sensitivity.
// - Bits 3..2: gap, header, header plus identifier, transparent.
// - Control bit 1 selects burst preamble mode, else continuous.
// - Control bit 0 enables the receiver.
// - Front-end reset acts only in transparent mode, else ignored.
module lfw_receiver
#(
   parameter TIMEOUT_CYC = `LFW_TIMEOUT_US * (`LFW_CLK_HZ / 1000000),
   parameter GAIN_W = 7
)
(
   // Clock and reset
   input wire i_core_clk,
   input wire i_srst,
   // AHB-Lite slave
   input wire i_hsel,
   input wire [7:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg o_hreadyout,
   output reg [31:0] o_hrdata,
   output reg o_hresp,
   // Analog front end
   input wire i_carrier_cmp,
   input wire i_amp_above_ref,
   output reg [2:0] o_trim_cap_select,
   output reg o_sensitivity_select,
   output reg [GAIN_W-1:0] o_agc_gain,
   output reg o_osc_enable,
   // Core side
   output reg o_raw_data_bit,
   output reg o_capture_timer_in,
   output reg o_wakeup_irq,
   output reg o_buffer_irq
);
   localparam PER_CYC = `LFW_CLK_HZ / `LFW_CARRIER_HZ;
   localparam [4:0] ST_LISTEN = 5'h01;
   localparam [4:0] ST_SYNC = 5'h02;
   localparam [4:0] ST_HDR = 5'h04;
   localparam [4:0] ST_DATA = 5'h08;
   localparam [4:0] ST_TRANSP = 5'h10;

   // Registers
   reg [7:0] rx_control_reg;
   reg rssi_capture_enable;
   reg front_end_reset;
   reg [7:0] receive_buffer;
   reg [GAIN_W-1:0] rssi_value_reg;
   reg [6:0] header_compare;
   reg [15:0] identifier_compare;
   reg rssi_ready_flag;
   reg eod_flag;
   reg buffer_full_flag;
   reg wake_flag;
   // Bus pipeline
   reg wr_pend;
   reg [7:0] wr_addr;
   reg [31:0] rd_mux;
   // Front end
   reg [1:0] cmp_sync;
   reg [1:0] ref_sync;
   reg [6:0] per_cnt;
   reg seen_hi;
   reg seen_ref;
   reg [1:0] hist;
   reg env;
   reg env_d;
   reg [2:0] low_per;
   // Receive control
   reg [4:0] state;
   reg [8:0] pre_cnt;
   reg [4:0] gap_cnt;
   reg [15:0] tmo_cnt;
   reg gap_seen;
   reg [22:0] shift;
   reg [4:0] bit_cnt;
   reg [2:0] byte_cnt;
   wire receiver_enable = rx_control_reg[`LFW_EN_BIT];
   wire [1:0] wake_mode_field = rx_control_reg[`LFW_MODE_HI:`LFW_MODE_LO];
   wire burst_preamble_enable = rx_control_reg[`LFW_BURST_BIT];
   wire per_tick = (per_cnt == PER_CYC[6:0] - 7'h01);
   wire bus_addr = i_hsel && i_hready && i_htrans[1];
   wire wr_ctrl = wr_pend && (wr_addr == `LFW_OFS_CTRL);
   wire wr_flag = wr_pend && (wr_addr == `LFW_OFS_FLAG);
   wire dec_bit;
   wire dec_val;
   wire dec_err;
   wire dec_run = (state == ST_HDR) || (state == ST_DATA);
   wire start_sync = gap_seen && env && !env_d;
   wire [22:0] next_shift = {shift[21:0], dec_val};
   reg [4:0] next_state;

   // Wake pattern check; header occupies the oldest bits
   function match;
      input [1:0] mode;
      input [4:0] cnt;
      input [22:0] bits;
      input [6:0] hdr;
      input [15:0] id;
   begin
      if (mode == `LFW_MODE_HDR)
         match = (cnt == `LFW_HDR_BITS) && (bits[6:0] == hdr);
      else
         match = (cnt == `LFW_HDR_BITS + `LFW_ID_BITS) && (bits == {hdr, id});
   end
   endfunction

   lfw_manchester u_dec
   (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_run(dec_run),
      .i_env(env),
      .o_bit_valid(dec_bit),
      .o_bit_value(dec_val),
      .o_bit_error(dec_err)
   );

   // Register read mux; reserved bits read as zero
   always @*
   begin
      rd_mux = 32'h00000000;
      case (i_haddr)
         `LFW_OFS_CTRL: rd_mux[7:0] = rx_control_reg;
         `LFW_OFS_CDATA: rd_mux[7:0] = {rssi_capture_enable,
            front_end_reset, 5'h00, o_raw_data_bit};
         `LFW_OFS_RXBUF: rd_mux[7:0] = receive_buffer;
         `LFW_OFS_RSSI: rd_mux[GAIN_W-1:0] = rssi_value_reg;
         `LFW_OFS_HDR: rd_mux[6:0] = header_compare;
         `LFW_OFS_ID: rd_mux[15:0] = identifier_compare;
         `LFW_OFS_FLAG: rd_mux[3:0] = {rssi_ready_flag, eod_flag,
            buffer_full_flag, wake_flag};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Zero wait state slave; unmapped addresses read zero, writes dropped
   always @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_hrdata <= 32'h00000000;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         wr_pend <= bus_addr && i_hwrite;
         if (bus_addr)
            wr_addr <= i_haddr;
         if (bus_addr && !i_hwrite)
            o_hrdata <= rd_mux;
      end
   end

   // Software registers
   always @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         rx_control_reg <= `LFW_CTRL_RESET;
         front_end_reset <= 1'b0;
         header_compare <= 7'h00;
         identifier_compare <= 16'h0000;
      end
      else if (wr_pend)
      begin
         if (wr_ctrl)
            rx_control_reg <= i_hwdata[7:0];
         if (wr_addr == `LFW_OFS_CDATA)
            front_end_reset <= i_hwdata[`LFW_FERST_BIT];
         if (wr_addr == `LFW_OFS_HDR)
            header_compare <= i_hwdata[6:0];
         if (wr_addr == `LFW_OFS_ID)
            identifier_compare <= i_hwdata[15:0];
      end
   end

   // Front-end outputs and pin synchronisers
   always @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         o_trim_cap_select <= 3'h0;
         o_sensitivity_select <= 1'b0;
         cmp_sync <= 2'h0;
         ref_sync <= 2'h0;
      end
      else
      begin
         o_trim_cap_select <= rx_control_reg[`LFW_TRIM_HI:`LFW_TRIM_LO];
         o_sensitivity_select <= rx_control_reg[`LFW_SENS_BIT];
         cmp_sync <= {cmp_sync[0], i_carrier_cmp};
         ref_sync <= {ref_sync[0], i_amp_above_ref};
      end
   end

   // Signal conditioner: per-period sampling of the half-reference compare.
   // Two high periods set the envelope, three quiet periods clear it, so
   // half-wave spaces, a missing period and gap glitches are swallowed.
   always @(posedge i_core_clk)
   begin
      if (i_srst || !receiver_enable)
      begin
         per_cnt <= 7'h00;
         seen_hi <= 1'b0;
         seen_ref <= 1'b0;
         hist <= 2'h0;
         env <= 1'b0;
         env_d <= 1'b0;
         low_per <= 3'h0;
         o_agc_gain <= {GAIN_W{1'b0}};
      end
      else
      begin
         env_d <= env;
         per_cnt <= per_tick ? 7'h00 : per_cnt + 7'h01;
         seen_hi <= per_tick ? 1'b0 : (seen_hi | cmp_sync[1]);
         seen_ref <= per_tick ? 1'b0 : (seen_ref | ref_sync[1]);
         if (per_tick)
         begin
            hist <= {hist[0], seen_hi};
            if (seen_hi && hist[0])
               env <= 1'b1;
            else if (!seen_hi && hist == 2'h0)
               env <= 1'b0;
            // Regulation halts once the signal drops below half reference
            if (!seen_hi)
               low_per <= 3'h0;
            else if (seen_ref)
            begin
               low_per <= 3'h0;
               if (o_agc_gain != {GAIN_W{1'b0}})
                  o_agc_gain <= o_agc_gain - 1'b1;
            end
            else if (low_per == `LFW_AGC_UP_PERIODS - 1)
            begin
               low_per <= 3'h0;
               if (o_agc_gain != {GAIN_W{1'b1}})
                  o_agc_gain <= o_agc_gain + 1'b1;
            end
            else
               low_per <= low_per + 3'h1;
         end
      end
   end

   // State transitions
   always @*
   begin
      next_state = state;
      case (state)
         ST_LISTEN:
            if (pre_cnt == `LFW_PREAMBLE_PERIODS)
               next_state = ST_SYNC;
         ST_SYNC:
            if (tmo_cnt == TIMEOUT_CYC[15:0])
               next_state = ST_LISTEN;
            else if (start_sync)
            begin
               if (wake_mode_field == `LFW_MODE_TRANSP)
                  next_state = ST_TRANSP;
               else if (wake_mode_field == `LFW_MODE_GAP)
                  next_state = ST_DATA;
               else
                  next_state = ST_HDR;
            end
         ST_HDR:
            if (tmo_cnt == TIMEOUT_CYC[15:0] || dec_err)
               next_state = ST_LISTEN;
            else if (dec_bit && match(wake_mode_field, bit_cnt + 5'h01,
               next_shift, header_compare, identifier_compare))
               next_state = ST_DATA;
         ST_DATA:
            if (dec_err)
               next_state = ST_LISTEN;
         ST_TRANSP:
            if (front_end_reset)
               next_state = ST_LISTEN;
         default: next_state = ST_LISTEN;
      endcase
   end

   // Preamble detector, timeout and frame assembly
   always @(posedge i_core_clk)
   begin
      if (i_srst || !receiver_enable)
      begin
         state <= ST_LISTEN;
         pre_cnt <= 9'h000;
         gap_cnt <= 5'h00;
         tmo_cnt <= 16'h0000;
         gap_seen <= 1'b0;
         shift <= 23'h000000;
         bit_cnt <= 5'h00;
         byte_cnt <= 3'h0;
         o_osc_enable <= 1'b0;
      end
      else
      begin
         state <= next_state;
         o_osc_enable <= (next_state != ST_LISTEN);
         // Hold in listen while a transparent reset is still asserted
         if (state != ST_LISTEN || (front_end_reset &&
            wake_mode_field == `LFW_MODE_TRANSP))
         begin
            pre_cnt <= 9'h000;
            gap_cnt <= 5'h00;
         end
         else if (per_tick && env)
         begin
            gap_cnt <= 5'h00;
            if (pre_cnt != `LFW_PREAMBLE_PERIODS)
               pre_cnt <= pre_cnt + 9'h001;
         end
         else if (per_tick)
         begin
            if (gap_cnt != 5'h1f)
               gap_cnt <= gap_cnt + 5'h01;
            if (gap_cnt >= (burst_preamble_enable ? `LFW_GAP_BURST
               : `LFW_GAP_CONT))
               pre_cnt <= 9'h000;
         end
         if (state == ST_SYNC || state == ST_HDR)
            tmo_cnt <= tmo_cnt + 16'h0001;
         else
            tmo_cnt <= 16'h0000;
         gap_seen <= (state == ST_SYNC) && (gap_seen || !env);
         if (state != next_state)
         begin
            shift <= 23'h000000;
            bit_cnt <= 5'h00;
            byte_cnt <= 3'h0;
         end
         else if (dec_bit)
         begin
            shift <= next_shift;
            if (bit_cnt != 5'h1f)
               bit_cnt <= bit_cnt + 5'h01;
            byte_cnt <= byte_cnt + 3'h1;
         end
      end
   end

   // Buffer, RSSI and sticky flags; a hardware set beats a clear
   always @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         receive_buffer <= 8'h00;
         rssi_value_reg <= {GAIN_W{1'b0}};
         rssi_capture_enable <= 1'b0;
         rssi_ready_flag <= 1'b0;
         eod_flag <= 1'b0;
         buffer_full_flag <= 1'b0;
         wake_flag <= 1'b0;
         o_raw_data_bit <= 1'b0;
         o_capture_timer_in <= 1'b0;
         o_wakeup_irq <= 1'b0;
         o_buffer_irq <= 1'b0;
      end
      else
      begin
         o_raw_data_bit <= env;
         o_capture_timer_in <= env;
         o_wakeup_irq <= wake_flag;
         o_buffer_irq <= buffer_full_flag;
         if (wr_pend && wr_addr == `LFW_OFS_CDATA &&
            i_hwdata[`LFW_CAPT_BIT])
            rssi_capture_enable <= 1'b1;
         else if (rssi_capture_enable)
            rssi_capture_enable <= 1'b0;
         if (rssi_capture_enable && receiver_enable)
            rssi_value_reg <= o_agc_gain;
         rssi_ready_flag <= (rssi_capture_enable && receiver_enable) ||
            (rssi_ready_flag && !(wr_flag && i_hwdata[`LFW_FLG_RSSI]));
         if (state == ST_DATA && dec_bit && byte_cnt == 3'h7)
            receive_buffer <= next_shift[7:0];
         buffer_full_flag <= (state == ST_DATA && dec_bit &&
            byte_cnt == 3'h7) || (buffer_full_flag &&
            !(wr_flag && i_hwdata[`LFW_FLG_BUF]));
         wake_flag <= (receiver_enable && next_state == ST_DATA &&
            state != ST_DATA) || (wake_flag &&
            !(wr_flag && i_hwdata[`LFW_FLG_WAKE]));
         eod_flag <= (receiver_enable && dec_err) || (eod_flag &&
            !(wr_flag && i_hwdata[`LFW_FLG_EOD]));
      end
   end
endmodule
`default_nettype wire

// [lfw_receiver_checker.sv]
// Port-level assertions for the LF wake-up receiver back end
`timescale 1ns/1ps
`default_nettype none
module lfw_checker
#(
   parameter TIMEOUT_CYC = 2500,
   parameter GAIN_W = 7
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Register bus
   input wire logic i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hresp,
   // Front end and core side
   input wire logic [2:0] o_trim_cap_select,
   input wire logic o_sensitivity_select,
   input wire logic [GAIN_W-1:0] o_agc_gain,
   input wire logic o_osc_enable,
   input wire logic o_raw_data_bit,
   input wire logic o_capture_timer_in,
   input wire logic o_wakeup_irq
);
   reg wr_dp;
   reg [7:0] wr_addr;
   reg [7:0] ctrl_sh;
   reg [2:0] en_hist;
   integer awake_cnt;
   wire take = i_hsel && i_hready && i_htrans[1];
   // Shadow of the control register, rebuilt from bus writes
   always @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         wr_dp <= 1'b0;
         wr_addr <= 8'h00;
         ctrl_sh <= 8'h00;
         en_hist <= 3'h0;
         awake_cnt <= 0;
      end
      else
      begin
         wr_dp <= take && i_hwrite;
         wr_addr <= i_haddr;
         if (wr_dp && wr_addr == 8'h00)
            ctrl_sh <= i_hwdata[7:0];
         en_hist <= {en_hist[1:0], ctrl_sh[0]};
         // Transparent mode is exempt: it waits for software
         if (o_osc_enable && !o_wakeup_irq && ctrl_sh[3:2] != 2'h3)
            awake_cnt <= awake_cnt + 1;
         else
            awake_cnt <= 0;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   sequence rd_ctrl;
      take && !i_hwrite && i_haddr == 8'h00;
   endsequence
   sequence rd_unmapped;
      take && !i_hwrite && i_haddr >= 8'h1c;
   endsequence
   sequence ctrl_settled;
      $stable(ctrl_sh) [*3];
   endsequence
   a_bus_okay: assert property (o_hreadyout && !o_hresp)
      else $error("bus not ready or error response");
   a_ctrl_readback: assert property (
      rd_ctrl |=> o_hrdata == {24'h0, $past(ctrl_sh)})
      else $error("control register read back wrong");
   a_unmapped_zero: assert property (rd_unmapped |=> o_hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_trim_sens_out: assert property (
      ctrl_settled |-> o_trim_cap_select == ctrl_sh[7:5]
         && o_sensitivity_select == ctrl_sh[4])
      else $error("trim or sensitivity output differs from control");
   // A wake flag left from before the disable may stand; a new one may not
   a_disabled_idle: assert property (
      en_hist == 3'h0 |-> !o_osc_enable && !$rose(o_wakeup_irq)
         && o_agc_gain == 0)
      else $error("receive logic active while disabled");
   a_raw_to_timer: assert property (
      o_capture_timer_in == o_raw_data_bit)
      else $error("capture input differs from raw bit");
   a_gain_one_step: assert property (
      !$stable(o_agc_gain) |-> o_agc_gain == $past(o_agc_gain) + 1'b1
         || o_agc_gain == $past(o_agc_gain) - 1'b1 || o_agc_gain == 0)
      else $error("gain moved by more than one step");
   a_wake_when_awake: assert property (
      $rose(o_wakeup_irq) |-> $past(o_osc_enable, 1) || $past(o_osc_enable, 2))
      else $error("wake-up flag without awake decoder");
   a_osc_from_env: assert property (
      $rose(o_osc_enable) |-> $past(o_raw_data_bit))
      else $error("decoder woke without envelope");
   a_timeout_bound: assert property (
      awake_cnt <= TIMEOUT_CYC + 200)
      else $error("decoder stayed awake past timeout");
endmodule
bind lfw_receiver lfw_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .GAIN_W(GAIN_W))
   lfw_checker_inst (.i_core_clk(i_core_clk), .i_srst(i_srst),
   .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
   .o_trim_cap_select(o_trim_cap_select),
   .o_sensitivity_select(o_sensitivity_select), .o_agc_gain(o_agc_gain),
   .o_osc_enable(o_osc_enable), .o_raw_data_bit(o_raw_data_bit),
   .o_capture_timer_in(o_capture_timer_in), .o_wakeup_irq(o_wakeup_irq));
`default_nettype wire

// [lfw_receiver_dummy_guard.v]
// Spare source slot for the LF wake-up receiver; holds no logic

// [tb_lfw_receiver.sv]
// Self-checking testbench for the LF wake-up receiver back end
`timescale 1ns/1ps
`default_nettype none
module tb_lfw_receiver;
   // Timeout shortened; preamble kept just over the detect count to fit it
   localparam int TO = 2500;
   localparam int PRE = 136;
   logic clk, srst, hsel, hwrite;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, rdv;
   wire hreadyout, hresp, sens, osc, raw, cap, wirq, birq, carr, amp;
   wire [31:0] hrdata;
   wire [2:0] trim;
   wire [6:0] gain;
   int err_total = 0;
   int n_checks = 0;
   lfw_receiver #(.TIMEOUT_CYC(TO)) lfw_receiver_inst (.i_core_clk(clk),
      .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hrdata(hrdata),
      .o_hresp(hresp), .i_carrier_cmp(carr), .i_amp_above_ref(amp),
      .o_trim_cap_select(trim), .o_sensitivity_select(sens),
      .o_agc_gain(gain), .o_osc_enable(osc), .o_raw_data_bit(raw),
      .o_capture_timer_in(cap), .o_wakeup_irq(wirq), .o_buffer_irq(birq));
   lfw_lf_tx lfw_lf_tx_inst (.i_core_clk(clk), .o_carrier_cmp(carr),
      .o_amp_above_ref(amp));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         err_total++;
         $display("MISMATCH t=%0t bus wait timed out", $time);
         report_and_stop();
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d, rdv);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input string what);
      xfer(a, 1'b0, 32'h0, rdv);
      chk(rdv, e, what);
   endtask
   task automatic t_regs();
      logic [7:0] v;
      rd_chk(8'h00, 32'h0, "ctrl reset");
      rd_chk(8'h18, 32'h0, "flags reset");
      rd_chk(8'h04, 32'h0, "cdata reset");
      for (int m = 0; m < 4; m++)
      begin
         v = {3'(7 - m), m[0], m[1:0], m[1], 1'b0};
         wr(8'h00, {24'h0, v});
         rd_chk(8'h00, {24'h0, v}, "ctrl readback");
         repeat (3) @(posedge clk);
         chk({29'h0, trim}, {29'h0, v[7:5]}, "trim out");
         chk({31'h0, sens}, {31'h0, v[4]}, "sens out");
      end
      wr(8'h1c, 32'hffffffff);
      rd_chk(8'h1c, 32'h0, "unmapped");
      wr(8'h10, 32'hffffffff);
      rd_chk(8'h10, 32'h7f, "header width");
      wr(8'h14, 32'hffffffff);
      rd_chk(8'h14, 32'hffff, "identifier width");
      wr(8'h00, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_rssi();
      wr(8'h00, 32'h01);
      wr(8'h04, 32'h80);
      repeat (3) @(posedge clk);
      rd_chk(8'h18, 32'h8, "rssi ready");
      rd_chk(8'h0c, 32'h0, "rssi no carrier");
      rd_chk(8'h04, 32'h0, "capture self clear");
      wr(8'h18, 32'h8);
      rd_chk(8'h18, 32'h0, "rssi flag clear");
      $display("test rssi done");
   endtask
   task automatic t_disabled();
      wr(8'h00, 32'h0);
      lfw_lf_tx_inst.preamble(PRE);
      chk({31'h0, osc}, 32'h0, "osc disabled");
      chk({25'h0, gain}, 32'h0, "gain disabled");
      lfw_lf_tx_inst.hold(1'b0, 1'b0, 5);
      rd_chk(8'h18, 32'h0, "no flags disabled");
      $display("test disabled done");
   endtask
   task automatic t_gap_data();
      wr(8'h00, 32'h01);
      chk({31'h0, osc}, 32'h0, "listen before carrier");
      lfw_lf_tx_inst.preamble(PRE);
      chk({31'h0, osc}, 32'h1, "awake after preamble");
      chk({31'h0, raw}, 32'h1, "envelope high");
      chk({31'h0, gain != 0}, 32'h1, "gain climbed");
      lfw_lf_tx_inst.hold(1'b0, 1'b0, 5);
      lfw_lf_tx_inst.manchester(32'ha5, 8);
      rd_chk(8'h08, 32'ha5, "receive buffer");
      chk({31'h0, wirq}, 32'h1, "wake irq");
      chk({31'h0, birq}, 32'h1, "buffer irq");
      xfer(8'h18, 1'b0, 32'h0, rdv);
      chk(rdv & 32'h3, 32'h3, "wake and full flags");
      repeat (6000) @(posedge clk);
      chk({31'h0, osc}, 32'h0, "auto return");
      wr(8'h18, 32'hf);
      rd_chk(8'h18, 32'h0, "flags cleared");
      $display("test gap data done");
   endtask
   task automatic t_timeout();
      lfw_lf_tx_inst.preamble(PRE);
      chk({31'h0, osc}, 32'h1, "awake for timeout");
      lfw_lf_tx_inst.hold(1'b0, 1'b0, 1);
      repeat (TO + 500) @(posedge clk);
      chk({31'h0, osc}, 32'h0, "timeout to listen");
      rd_chk(8'h18, 32'h0, "no flag on timeout");
      $display("test timeout done");
   endtask
   task automatic t_transparent();
      wr(8'h00, 32'h0f);
      lfw_lf_tx_inst.preamble(PRE);
      chk({31'h0, osc}, 32'h1, "burst preamble awake");
      rd_chk(8'h04, 32'h1, "raw bit high");
      chk({31'h0, cap}, 32'h1, "capture input high");
      lfw_lf_tx_inst.hold(1'b0, 1'b0, 5);
      rd_chk(8'h04, 32'h0, "raw bit low");
      // Start burst after the gap, else the sync wait times out
      lfw_lf_tx_inst.hold(1'b1, 1'b0, 3);
      repeat (TO + 500) @(posedge clk);
      chk({31'h0, osc}, 32'h1, "no auto return");
      wr(8'h04, 32'h40);
      repeat (3) @(posedge clk);
      chk({31'h0, osc}, 32'h0, "front end reset");
      // Carrier is still on, so the raw bit reads one
      rd_chk(8'h04, 32'h41, "reset bit reads");
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0);
      $display("test transparent done");
   endtask
   initial
   begin
      srst = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_rssi();
      t_disabled();
      t_gap_data();
      t_timeout();
      t_transparent();
      report_and_stop();
   end
endmodule
`default_nettype wire
